// *** bench/dmac_mem_model.sv ***
// memory model for the dma master port, answers rotating through 0, 1 and 2 wait cycles
`timescale 1ns/1ps
module dmac_mem_model
  import dmac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dmac_mem_s mem_i,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [0:255];
  int wait_cnt;
  int slow;
  // fixed fill pattern so the bench knows every source word
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 32'h1000_0000 + i;
    end
  end
  // answer after 0..2 idle cycles; read data toggles while not valid
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'hA5A5_A5A5;
      wait_cnt <= 0;
      slow <= 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_i.req && !mem_ack) begin
        if (wait_cnt >= slow) begin
          mem_ack <= 1'b1;
          wait_cnt <= 0;
          slow <= (slow + 1) % 3;
          if (mem_i.we) begin
            ram[mem_i.addr[9:2]] <= mem_i.wdata;
          end else begin
            mem_rdata <= ram[mem_i.addr[9:2]];
          end
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule

// *** bench/dmac_top_tb_top.sv ***
// self-checking bench for the four channel dma engine
`timescale 1ns/1ps
module dmac_top_tb_top
  import dmac_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] dreq_i = 4'h0;
  dmac_mem_s mem_o;
  logic mem_ack;
  logic [31:0] mem_rdata;
  logic irq_o;
  logic dtu_stop_o;
  int miscompares = 0;
  int n_compared = 0;
  int n_wr = 0;
  int cycles = 0;
  logic [1:0] wr_size = 2'b00;
  logic [31:0] rd;
  int t;

  dmac_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dreq_i(dreq_i),
    .mem_o(mem_o), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .irq_o(irq_o),
    .dtu_stop_o(dtu_stop_o));
  dmac_mem_model u_mem (.clk_sys(clk_sys), .sys_rst(sys_rst), .mem_i(mem_o),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // count finished data units and note the width used; also the hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (mem_o.req && mem_o.we && mem_ack) begin
      n_wr <= n_wr + 1;
      wr_size <= mem_o.size;
    end
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // one classic wishbone cycle; no cycle count assumed for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) begin
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg_%h", a), e, rd);
  endtask
  // status lands one cycle after the last write ack, irq one more
  task automatic wait_units(input int target);
    t = 0;
    while (n_wr < target && t < 2000) begin
      @(posedge clk_sys);
      t++;
    end
    if (t >= 2000) begin
      miscompares++;
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_sys);
    dreq_i <= v;
    @(posedge clk_sys);
    dreq_i <= 4'h0;
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rc(8'h88, 32'h0000_0000);
    chk("dtu_stop", 0, dtu_stop_o);
    rc(8'hFC, 32'h0000_0000);
    // channel 1 normal: src inc, dst dec, longword, two units
    wr(8'h20, 32'h0000_0100);
    wr(8'h24, 32'h0000_020C);
    wr(8'h28, 32'h0000_0002);
    wr(8'h30, 32'h0000_00A4);
    wr(8'h34, 32'h0000_0001);
    wr(8'h84, 32'h0000_0002);
    // stopped engine must hold a latched request until released
    wr(8'h88, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("dtu_stop", 1, dtu_stop_o);
    pulse(4'h2);
    repeat (20) @(posedge clk_sys);
    chk("units", 0, n_wr);
    wr(8'h88, 32'h0000_0000);
    wait_units(1);
    rc(8'h80, 32'h0000_0000);
    chk("irq", 0, irq_o);
    pulse(4'h2);
    wait_units(2);
    chk("dst_word0", 32'h1000_0040, u_mem.ram[8'h83]);
    chk("dst_word1", 32'h1000_0041, u_mem.ram[8'h82]);
    chk("width", 2, wr_size);
    rc(8'h20, 32'h0000_0108);
    rc(8'h24, 32'h0000_0204);
    rc(8'h80, 32'h0000_0002);
    chk("irq", 1, irq_o);
    rc(8'h34, 32'h0000_0000);
    wr(8'h84, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    chk("irq_masked", 0, irq_o);
    wr(8'h84, 32'h0000_0002);
    wr(8'h80, 32'h0000_0002);
    repeat (3) @(posedge clk_sys);
    chk("irq_cleared", 0, irq_o);
    // channels 0 and 1 request together; offset step only on channel 0
    wr(8'h00, 32'h0000_0300);
    wr(8'h04, 32'h0000_0320);
    wr(8'h08, 32'h0000_0001);
    wr(8'h10, 32'h0000_008C);
    wr(8'h18, 32'h0000_0010);
    wr(8'h14, 32'h0000_0001);
    wr(8'h20, 32'h0000_0340);
    wr(8'h24, 32'h0000_0360);
    wr(8'h28, 32'h0000_0001);
    wr(8'h30, 32'h0000_008C);
    wr(8'h34, 32'h0000_0001);
    pulse(4'h3);
    t = 0;
    while (mem_o.req !== 1'b1 && t < 100) begin
      @(posedge clk_sys);
      t++;
    end
    chk("first_addr", 32'h0000_0300, mem_o.addr);
    wait_units(4);
    rc(8'h00, 32'h0000_0310);
    rc(8'h20, 32'h0000_0340);
    rc(8'h38, 32'h0000_0000);
    wr(8'h80, 32'h0000_0003);
    // channel 2 repeat: word, dst area, stop at each repeat end
    wr(8'h40, 32'h0000_0400);
    wr(8'h44, 32'h0000_0500);
    wr(8'h48, 32'h0000_0002);
    wr(8'h4C, 32'h0000_0002);
    wr(8'h50, 32'h0000_0355);
    for (int k = 5; k <= 8; k++) begin
      wr(8'h54, 32'h0000_0003);
      wait_units(k);
      if (k == 6) begin
        chk("width", 1, wr_size);
        rc(8'h44, 32'h0000_0500);
        rc(8'h40, 32'h0000_0404);
        rc(8'h80, 32'h0000_0040);
        rc(8'h54, 32'h0000_0000);
        wr(8'h80, 32'h0000_0040);
      end
    end
    rc(8'h44, 32'h0000_0500);
    rc(8'h40, 32'h0000_0408);
    rc(8'h80, 32'h0000_0044);
    rc(8'h54, 32'h0000_0000);
    wr(8'h80, 32'h0000_0044);
    // channel 3 block: byte, src area, three units for one request
    wr(8'h60, 32'h0000_0600);
    wr(8'h64, 32'h0000_0700);
    wr(8'h68, 32'h0000_0003);
    wr(8'h6C, 32'h0000_0001);
    wr(8'h70, 32'h0000_0016);
    wr(8'h74, 32'h0000_0003);
    wait_units(11);
    repeat (20) @(posedge clk_sys);
    chk("units", 11, n_wr);
    chk("width", 0, wr_size);
    rc(8'h60, 32'h0000_0600);
    rc(8'h64, 32'h0000_0703);
    rc(8'h80, 32'h0000_0008);
    rc(8'h74, 32'h0000_0000);
    summarize();
  end
endmodule

// *** include/dmac_params.svh ***
// register offsets, field positions and reset values of the dma channel block
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
// byte address = {global, channel[1:0], word index[2:0], 2'b00}
`define DMAC_GLOBAL_BIT 7
`define DMAC_R_SAR 3'h0
`define DMAC_R_DAR 3'h1
`define DMAC_R_CRA 3'h2
`define DMAC_R_CRB 3'h3
`define DMAC_R_MODE 3'h4
`define DMAC_R_EN 3'h5
`define DMAC_R_OFS 3'h6
`define DMAC_G_STAT 3'h0
`define DMAC_G_MASK 3'h1
`define DMAC_G_MSTOP 3'h2
// enable register fields
`define DMAC_EN_BIT 0
`define DMAC_SWREQ_BIT 1
// reset values
`define DMAC_MSTOP_RST 1'h0
`define DMAC_ADDR_RST 32'h0000_0000
`define DMAC_CRA_RST 16'h0000
`define DMAC_CRB_RST 11'h000
`define DMAC_CRA_ONE 16'h0001
`define DMAC_CRB_ONE 11'h001
`endif

// *** include/dmac_pkg.sv ***
// types shared by the dma channel block
package dmac_pkg;
  typedef enum logic [1:0] {
    DMAC_NORMAL = 2'b00,
    DMAC_REPEAT = 2'b01,
    DMAC_BLOCK = 2'b10,
    DMAC_RSVD = 2'b11
  } dmac_mode_e;
  typedef enum logic [1:0] {
    DMAC_FIX = 2'b00,
    DMAC_INC = 2'b01,
    DMAC_DEC = 2'b10,
    DMAC_OFS = 2'b11
  } dmac_upd_e;
  typedef enum logic [1:0] {
    DMAC_ST_IDLE = 2'b00,
    DMAC_ST_READ = 2'b01,
    DMAC_ST_WRITE = 2'b10,
    DMAC_ST_NEXT = 2'b11
  } dmac_state_e;
  // mode register b layout, lsb first: mode, src update, dst update, size, area, repeat stop
  typedef struct packed {
    logic rpt_stop;
    logic area_dst;
    logic [1:0] size;
    dmac_upd_e dupd;
    dmac_upd_e supd;
    dmac_mode_e mode;
  } dmac_mode_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmac_mem_s;
endpackage

// *** verilog/dmac_addr.sv ***
// next transfer address: fixed, increment, decrement or add offset
`timescale 1ns/1ps
module dmac_addr
  import dmac_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic [AW-1:0] addr,
  input wire dmac_upd_e upd,
  input wire logic [1:0] size,
  input wire logic [AW-1:0] ofs,
  input wire logic ofs_ok,
  output logic [AW-1:0] next
);
  // unit width 8, 16 or 32 bits gives a step of 1, 2 or 4 bytes
  function automatic logic [AW-1:0] step_of(input logic [1:0] sz);
    step_of = (sz == 2'h2) ? AW'(4) : (sz == 2'h1) ? AW'(2) : AW'(1);
  endfunction
  wire [AW-1:0] step = step_of(size);
  // offset mode on a channel without offset hardware leaves the address alone
  assign next = (upd == DMAC_INC) ? addr + step :
                (upd == DMAC_DEC) ? addr - step :
                (upd == DMAC_OFS && ofs_ok) ? addr + ofs : addr;
endmodule

// *** verilog/dmac_arb.sv ***
// fixed priority arbiter, lowest index wins
`timescale 1ns/1ps
module dmac_arb
  import dmac_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic [NCH-1:0] req,
  output logic any,
  output logic [1:0] idx
);
  logic [NCH-1:0] lower;
  logic [1:0] pick [NCH+1];
  // lower[i] tells that some channel below i is asking
  assign lower[0] = 1'b0;
  assign pick[NCH] = 2'h0;
  genvar i;
  generate
    for (i = 1; i < NCH; i++) begin : g_low
      assign lower[i] = lower[i-1] | req[i-1];
    end
    for (i = 0; i < NCH; i++) begin : g_pick
      assign pick[i] = (req[i] && !lower[i]) ? 2'(i) : pick[i+1];
    end
  endgenerate
  assign any = |req;
  assign idx = pick[0];
endmodule

// *** verilog/dmac_top.sv ***
// four channel dma engine with wishbone registers and a memory master port
// How it works
// - normal mode: one unit per request, 65536 runs
// - addresses update independently; offset only channel zero
// - unit width byte, word or longword
// - repeat mode: one unit, size up to 65536, count up to 2048
// - repeat size done: repeat area address restored
// - repeat count exhausted ends the run
// - repeat end interrupt; enable write resumes
// - block mode: whole block per request
// - block length taken from count register a
// - area bit picks source or destination
// - engine runs after reset, not stopped
// - module stop also stops transfer unit
// - transfer end interrupt when count reached
// - fixed priority, channel zero highest
`timescale 1ns/1ps
`include "dmac_params.svh"
module dmac_top
  import dmac_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NCH-1:0] dreq_i,
  output dmac_mem_s mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic irq_o,
  output logic dtu_stop_o
);
  if (NCH < 1 || NCH > 4) begin : g_bad
    $error("dmac_top: NCH must be 1 to 4");
  end
  // every property below runs on the system clock and sleeps through reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [31:0] sar_reg [NCH];
  logic [31:0] dar_reg [NCH];
  logic [31:0] sar_ini_reg [NCH];
  logic [31:0] dar_ini_reg [NCH];
  logic [15:0] cra_reg [NCH];
  logic [15:0] rld_reg [NCH];
  logic [10:0] crb_reg [NCH];
  dmac_mode_s md_reg [NCH];
  logic [NCH-1:0] en_reg;
  logic [NCH-1:0] pend_reg;
  logic [31:0] ofs_reg;
  logic [2*NCH-1:0] sts_reg;
  logic [2*NCH-1:0] mask_reg;
  logic mstop_reg;
  logic ack_reg;
  logic [31:0] rd_reg;
  logic irq_reg;
  logic dtu_stop_reg;
  dmac_mem_s mem_reg;
  dmac_state_e st_reg;
  logic [1:0] cur_reg;
  logic first_reg;

  // byte lanes of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (d & m);
  endfunction

  // bus decode; a write lands on the edge where the master sees ack
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire wr = bus_req & wb_we_i & ack_reg;
  wire glob = wb_adr_i[`DMAC_GLOBAL_BIT];
  wire [1:0] wch = wb_adr_i[6:5];
  wire [2:0] widx = wb_adr_i[4:2];
  wire ch_ok = (32'(wch) < NCH);
  wire gwr = wr & glob;
  wire cwr = wr & ~glob & ch_ok;
  // narrow registers merged once; only the addressed channel takes the result
  wire [31:0] cra_mrg = merge({16'h0000, cra_reg[wch]}, wb_dat_i, wb_sel_i);
  wire [31:0] crb_mrg = merge({21'h0, crb_reg[wch]}, wb_dat_i, wb_sel_i);
  wire [31:0] md_mrg = merge({22'h0, md_reg[wch]}, wb_dat_i, wb_sel_i);

  // current channel view
  dmac_mode_s cmd;
  assign cmd = md_reg[cur_reg];
  wire [15:0] ccra = cra_reg[cur_reg];
  wire [10:0] ccrb = crb_reg[cur_reg];
  wire [31:0] csar = sar_reg[cur_reg];
  wire [31:0] cdar = dar_reg[cur_reg];
  logic [31:0] sar_upd;
  logic [31:0] dar_upd;

  // engine events: one unit written back
  wire done = (st_reg == DMAC_ST_WRITE) && mem_ack_i;
  wire cnt_last = (ccra == `DMAC_CRA_ONE);
  wire is_norm = (cmd.mode == DMAC_NORMAL);
  wire is_rep = (cmd.mode == DMAC_REPEAT);
  wire is_blk = (cmd.mode == DMAC_BLOCK);
  wire restore = cnt_last && !is_norm;
  wire run_last = cnt_last && (is_norm || ccrb == `DMAC_CRB_ONE);
  wire en_clr = run_last || (is_rep && cnt_last && cmd.rpt_stop);
  wire blk_more = is_blk && !cnt_last;

  // next values for the current channel
  wire [31:0] sar_nx = (restore && !cmd.area_dst) ? sar_ini_reg[cur_reg] : sar_upd;
  wire [31:0] dar_nx = (restore && cmd.area_dst) ? dar_ini_reg[cur_reg] : dar_upd;
  wire [15:0] cra_nx = restore ? rld_reg[cur_reg] : ccra - 16'h0001;
  wire [10:0] crb_nx = restore ? ccrb - 11'h001 : ccrb;

  dmac_addr #(.AW(32)) u_src (
    .addr(csar),
    .upd(cmd.supd),
    .size(cmd.size),
    .ofs(ofs_reg),
    .ofs_ok(cur_reg == 2'h0),
    .next(sar_upd)
  );
  dmac_addr #(.AW(32)) u_dst (
    .addr(cdar),
    .upd(cmd.dupd),
    .size(cmd.size),
    .ofs(ofs_reg),
    .ofs_ok(cur_reg == 2'h0),
    .next(dar_upd)
  );

  // arbitration over pending and enabled channels; stopped module starts nothing
  logic g_any;
  logic [1:0] g_idx;
  wire [NCH-1:0] elig = pend_reg & en_reg;
  dmac_arb #(.NCH(NCH)) u_arb (
    .req(elig),
    .any(g_any),
    .idx(g_idx)
  );
  wire go = (st_reg == DMAC_ST_IDLE) && g_any && !mstop_reg;

  // events into status: low half transfer end, high half repeat end
  logic [2*NCH-1:0] ev;
  always_comb begin
    ev = '0;
    if (done && run_last) ev[cur_reg] = 1'b1;
    if (done && is_rep && cnt_last) ev[NCH+32'(cur_reg)] = 1'b1;
  end
  wire [2*NCH-1:0] w1c = (gwr && widx == `DMAC_G_STAT) ? wb_dat_i[2*NCH-1:0] : '0;

  // per channel registers; software enable write wins so a handler can resume
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NCH; i++) begin
        sar_reg[i] <= `DMAC_ADDR_RST;
        dar_reg[i] <= `DMAC_ADDR_RST;
        sar_ini_reg[i] <= `DMAC_ADDR_RST;
        dar_ini_reg[i] <= `DMAC_ADDR_RST;
        cra_reg[i] <= `DMAC_CRA_RST;
        rld_reg[i] <= `DMAC_CRA_RST;
        crb_reg[i] <= `DMAC_CRB_RST;
        md_reg[i] <= '0;
      end
      en_reg <= '0;
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (done && 32'(cur_reg) == i) begin
          sar_reg[i] <= sar_nx;
          dar_reg[i] <= dar_nx;
          cra_reg[i] <= cra_nx;
          crb_reg[i] <= crb_nx;
          if (en_clr) en_reg[i] <= 1'b0;
        end
        if (cwr && 32'(wch) == i) begin
          case (widx)
            `DMAC_R_SAR: begin
              sar_reg[i] <= merge(sar_reg[i], wb_dat_i, wb_sel_i);
              sar_ini_reg[i] <= merge(sar_reg[i], wb_dat_i, wb_sel_i);
            end
            `DMAC_R_DAR: begin
              dar_reg[i] <= merge(dar_reg[i], wb_dat_i, wb_sel_i);
              dar_ini_reg[i] <= merge(dar_reg[i], wb_dat_i, wb_sel_i);
            end
            `DMAC_R_CRA: begin
              cra_reg[i] <= cra_mrg[15:0];
              rld_reg[i] <= cra_mrg[15:0];
            end
            `DMAC_R_CRB: crb_reg[i] <= crb_mrg[10:0];
            `DMAC_R_MODE: md_reg[i] <= dmac_mode_s'(md_mrg[9:0]);
            `DMAC_R_EN: begin
              if (wb_sel_i[0]) en_reg[i] <= wb_dat_i[`DMAC_EN_BIT];
            end
            default: ;
          endcase
        end
      end
      // request lines and software starts are sticky; a new one beats the grant clear
      pend_reg <= (pend_reg & ~((go ? NCH'(1) << g_idx : '0))) | dreq_i
                  | ((cwr && widx == `DMAC_R_EN && wb_sel_i[0] && wb_dat_i[`DMAC_SWREQ_BIT])
                     ? NCH'(1) << wch : '0);
    end
  end

  // global registers; hardware set beats the write-one clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sts_reg <= '0;
      mask_reg <= '0;
      mstop_reg <= `DMAC_MSTOP_RST;
      ofs_reg <= `DMAC_ADDR_RST;
      irq_reg <= 1'b0;
      dtu_stop_reg <= 1'b0;
    end else begin
      sts_reg <= (sts_reg & ~w1c) | ev;
      if (gwr && widx == `DMAC_G_MASK) mask_reg <= wb_dat_i[2*NCH-1:0];
      if (gwr && widx == `DMAC_G_MSTOP) mstop_reg <= wb_dat_i[0];
      if (cwr && wch == 2'h0 && widx == `DMAC_R_OFS) ofs_reg <= merge(ofs_reg, wb_dat_i, wb_sel_i);
      irq_reg <= |(sts_reg & mask_reg);
      dtu_stop_reg <= mstop_reg;
    end
  end

  // read mux; unmapped words read zero
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    if (glob) begin
      case (widx)
        `DMAC_G_STAT: rd = 32'(sts_reg);
        `DMAC_G_MASK: rd = 32'(mask_reg);
        `DMAC_G_MSTOP: rd = {31'h0, mstop_reg};
        default: rd = 32'h0000_0000;
      endcase
    end else if (ch_ok) begin
      case (widx)
        `DMAC_R_SAR: rd = sar_reg[wch];
        `DMAC_R_DAR: rd = dar_reg[wch];
        `DMAC_R_CRA: rd = {16'h0000, cra_reg[wch]};
        `DMAC_R_CRB: rd = {21'h0, crb_reg[wch]};
        `DMAC_R_MODE: rd = {22'h0, md_reg[wch]};
        `DMAC_R_EN: rd = {30'h0, pend_reg[wch], en_reg[wch]};
        `DMAC_R_OFS: rd = (wch == 2'h0) ? ofs_reg : 32'h0000_0000;
        default: rd = 32'h0000_0000;
      endcase
    end
  end

  // classic slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) rd_reg <= rd;
    end
  end

  // transfer engine: read a unit, write it, then idle or fetch the next block unit
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= DMAC_ST_IDLE;
      cur_reg <= 2'h0;
      mem_reg <= '0;
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
      case (st_reg)
        DMAC_ST_IDLE: if (go) begin
          cur_reg <= g_idx;
          mem_reg <= {1'b1, 1'b0, md_reg[g_idx].size, sar_reg[g_idx], 32'h0000_0000};
          st_reg <= DMAC_ST_READ;
        end
        DMAC_ST_READ: if (mem_ack_i) begin
          mem_reg <= {1'b1, 1'b1, cmd.size, cdar, mem_rdata_i};
          st_reg <= DMAC_ST_WRITE;
        end
        DMAC_ST_WRITE: if (mem_ack_i) begin
          mem_reg.req <= 1'b0;
          st_reg <= blk_more ? DMAC_ST_NEXT : DMAC_ST_IDLE;
        end
        DMAC_ST_NEXT: begin
          mem_reg <= {1'b1, 1'b0, cmd.size, csar, 32'h0000_0000};
          st_reg <= DMAC_ST_READ;
        end
        default: st_reg <= DMAC_ST_IDLE;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
  assign mem_o = mem_reg;
  assign irq_o = irq_reg;
  assign dtu_stop_o = dtu_stop_reg;

  // a normal unit ends in idle with the memory request dropped
  sequence s_unit_done;
    (st_reg == DMAC_ST_IDLE) && !mem_reg.req;
  endsequence
  property p_norm_one;
    (done && is_norm) |=> s_unit_done;
  endproperty
  a_norm_one: assert property (p_norm_one) else $error("normal unit not single");
  property p_size;
    mem_reg.req |-> mem_reg.size == cmd.size;
  endproperty
  a_size: assert property (p_size) else $error("unit width mismatch");
  property p_rep_restore;
    (done && is_rep && cnt_last) |=> (cmd.area_dst ? (cdar == $past(dar_ini_reg[cur_reg]))
                                                   : (csar == $past(sar_ini_reg[cur_reg])));
  endproperty
  a_rep_restore: assert property (p_rep_restore) else $error("repeat area not restored");
  property p_rep_end;
    (done && is_rep && cnt_last && ccrb == `DMAC_CRB_ONE) |=> !en_reg[cur_reg];
  endproperty
  a_rep_end: assert property (p_rep_end) else $error("repeat run did not end");
  property p_rep_irq;
    (done && is_rep && cnt_last) |=> sts_reg[NCH+32'(cur_reg)] ##1 1'b1;
  endproperty
  a_rep_irq: assert property (p_rep_irq) else $error("repeat end flag missing");
  sequence s_blk_refetch;
    (st_reg == DMAC_ST_NEXT) ##1 (st_reg == DMAC_ST_READ && mem_reg.req && !mem_reg.we);
  endsequence
  property p_blk_more;
    (done && blk_more) |=> s_blk_refetch;
  endproperty
  a_blk_more: assert property (p_blk_more) else $error("block stopped early");
  property p_blk_area;
    (done && is_blk && cnt_last) |=> (cmd.area_dst ? (cdar == $past(dar_ini_reg[cur_reg]))
                                                   : (csar == $past(sar_ini_reg[cur_reg])));
  endproperty
  a_blk_area: assert property (p_blk_area) else $error("block area not restored");
  property p_rst_run;
    first_reg |-> !mstop_reg && !dtu_stop_o;
  endproperty
  a_rst_run: assert property (p_rst_run) else $error("stopped after reset");
  property p_stop;
    (st_reg == DMAC_ST_IDLE && mstop_reg) |=> st_reg == DMAC_ST_IDLE && dtu_stop_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");
  property p_te;
    (done && run_last) |=> sts_reg[cur_reg] && !en_reg[cur_reg] || $past(cwr);
  endproperty
  a_te: assert property (p_te) else $error("transfer end flag missing");
  property p_prio;
    (go && elig[0]) |=> cur_reg == 2'h0 && st_reg == DMAC_ST_READ;
  endproperty
  a_prio: assert property (p_prio) else $error("priority broken");
endmodule
